//--- hw/ephy_basic_control.sv
// Emulated PHY basic control register with loopback, isolate and negotiation
`timescale 1ns/10ps
module ephy_basic_control
  import ephy_pkg::*;
#(
  parameter int DATA_W = 4                   // MII nibble width
)
(
  input  wire logic              core_clk_i,         // System clock, 20 MHz
  input  wire logic              resetn_i,           // Async chip reset, active low
  // Memory-mapped access
  input  wire logic [11:0]       mm_addr_i,          // Byte address
  input  wire logic              mm_wr_i,            // Write strobe
  input  wire logic              mm_rd_i,            // Read strobe
  input  wire logic [31:0]       mm_wdata_i,         // Write data
  output logic [31:0]            mm_rdata_o,         // Read data, one cycle later
  // Configuration loader
  input  wire logic              load_i,             // Loader write strobe
  input  wire logic [15:0]       load_data_i,        // Loader register image
  // Straps and mode
  input  wire logic [4:0]        phy_addr_strap_i,   // Serial address strap
  input  wire logic [1:0]        port_mode_i,        // Port mode, ephy_mode_e
  // Serial management pins
  input  wire logic              mdc_i,              // Management clock
  input  wire logic              mdio_i,             // Management data in
  output logic                   mdio_o,             // Management data out
  output logic                   mdio_oe_o,          // Management data enable
  // Negotiation partner abilities
  input  wire logic              partner_fast_i,     // Partner does 100/200
  input  wire logic              partner_full_i,     // Partner does full duplex
  // MAC-facing MII pins
  input  wire logic              mac_tx_en_i,        // Transmit enable from MAC
  input  wire logic [DATA_W-1:0] mac_txd_i,          // Transmit data from MAC
  output logic                   mac_rx_dv_o,        // Receive valid to MAC
  output logic [DATA_W-1:0]      mac_rxd_o,          // Receive data to MAC
  output logic                   mac_col_o,          // Collision to MAC
  output logic                   mac_out_oe_o,       // MII output drive enable
  output logic                   mii_pull_en_o,      // MII pull resistors enable
  // Switch fabric side
  output logic                   fabric_tx_valid_o,  // Frame data into fabric
  output logic [DATA_W-1:0]      fabric_txd_o,       // Data into fabric
  input  wire logic              fabric_rx_valid_i,  // Frame data from fabric
  input  wire logic [DATA_W-1:0] fabric_rxd_i,       // Data from fabric
  // Status
  output logic                   link_fast_o,        // Effective speed 100/200
  output logic                   link_full_o,        // Effective full duplex
  output logic                   neg_done_o,         // Negotiation complete
  output logic                   soft_reset_o        // Pulse to other emulated regs
);

  // Stored control bits only; the self-clearing reset bit has no storage
  typedef struct packed {
    logic              loop;
    logic              speed;
    logic              neg_en;
    logic              pwr_dn;
    logic              iso;
    logic              restart;
    logic              duplex;
    logic              col_test;
  } ephy_ctrl_s;

  typedef struct packed {
    ephy_ctrl_s        ctrl;
    logic              neg_busy;
    logic [7:0]        neg_cnt;
    logic              neg_fast;
    logic              neg_full;
    logic              neg_done;
    logic              strap_taken;
    logic [4:0]        phy_addr;
    logic [31:0]       rdata;
    logic              soft_rst;
    logic [1:0]        tx_en_sync;
    logic [DATA_W-1:0] txd_s1;
    logic [DATA_W-1:0] txd_s2;
    logic              rx_dv;
    logic [DATA_W-1:0] rxd;
    logic              col;
    logic              fab_valid;
    logic [DATA_W-1:0] fab_d;
  } ephy_state_s;

  ephy_state_s r;
  ephy_state_s next_r;

  logic        ser_wr;
  logic [15:0] ser_wdata;
  logic [4:0]  ser_index;
  logic [15:0] ser_rdata;
  logic [15:0] ctrl_view;
  logic        phy_mode;
  logic        isolated;
  logic        tx_en_eff;

  //////////////////////////////////////////////////////////////////////////////
  // Bit 15 is an action, bit 6 and the reserved bits are not stored
  function automatic logic [15:0] ctrl_pack(input ephy_ctrl_s c);
    logic [15:0] v;
    v                    = 16'h0000;
    v[EPHY_BIT_LOOP]     = c.loop;
    v[EPHY_BIT_SPEED]    = c.speed;
    v[EPHY_BIT_NEG_EN]   = c.neg_en;
    v[EPHY_BIT_PWR_DN]   = c.pwr_dn;
    v[EPHY_BIT_ISO]      = c.iso;
    v[EPHY_BIT_RESTART]  = c.restart;
    v[EPHY_BIT_DUPLEX]   = c.duplex;
    v[EPHY_BIT_COL_TEST] = c.col_test;
    ctrl_pack            = v;
  endfunction

  function automatic ephy_ctrl_s ctrl_unpack(input logic [15:0] v);
    ephy_ctrl_s c;
    c.loop     = v[EPHY_BIT_LOOP];
    c.speed    = v[EPHY_BIT_SPEED];
    c.neg_en   = v[EPHY_BIT_NEG_EN];
    c.pwr_dn   = v[EPHY_BIT_PWR_DN];
    c.iso      = v[EPHY_BIT_ISO];
    c.restart  = v[EPHY_BIT_RESTART];
    c.duplex   = v[EPHY_BIT_DUPLEX];
    c.col_test = v[EPHY_BIT_COL_TEST];
    ctrl_unpack = c;
  endfunction

  // Address and index match are each decoded in two places
  function automatic logic ctrl_addr_hit(input logic [11:0] a);
    ctrl_addr_hit = (a == EPHY_CTRL_OFFSET);
  endfunction

  function automatic logic ctrl_index_hit(input logic [4:0] i);
    ctrl_index_hit = (i == EPHY_CTRL_INDEX);
  endfunction

  // Register image after chip or soft reset
  localparam ephy_ctrl_s CTRL_DEFAULT = ctrl_unpack(EPHY_CTRL_RESET);

  //////////////////////////////////////////////////////////////////////////////
  // Serial access is gated until the strap is held and the port is a PHY
  ephy_mdio_slave u_mdio (
    .core_clk_i  (core_clk_i),
    .resetn_i    (resetn_i),
    .mdc_i       (mdc_i),
    .mdio_i      (mdio_i),
    .mdio_o      (mdio_o),
    .mdio_oe_o   (mdio_oe_o),
    .enable_i    (phy_mode && r.strap_taken),
    .phy_addr_i  (r.phy_addr),
    .rd_data_i   (ser_rdata),
    .reg_index_o (ser_index),
    .wr_o        (ser_wr),
    .wr_data_o   (ser_wdata)
  );

  //////////////////////////////////////////////////////////////////////////////
  assign ctrl_view = ctrl_pack(r.ctrl);
  // Only index 0 lives here; other indexes read as zero from this block
  assign ser_rdata = ctrl_index_hit(ser_index) ? ctrl_view : 16'h0000;
  assign phy_mode  = ephy_is_phy_mode(port_mode_i);
  assign isolated  = phy_mode && r.ctrl.iso;
  // Isolated inputs are ignored: the synchronised MAC transmit looks idle
  assign tx_en_eff = r.tx_en_sync[1] && !isolated;

  // One pass computes the whole next state of the register and datapath
  always_comb
  begin
    logic        wr_hit;
    logic [15:0] wval;
    logic        start_neg;
    next_r          = r;
    wr_hit          = 1'b0;
    wval            = 16'h0000;
    start_neg       = 1'b0;
    next_r.soft_rst = 1'b0;

    // Strap is caught on the first edge after reset release
    if (!r.strap_taken)
    begin
      next_r.strap_taken = 1'b1;
      next_r.phy_addr    = phy_addr_strap_i;
    end

    // Memory-mapped write wins over a serial write in the same cycle
    if (mm_wr_i && ctrl_addr_hit(mm_addr_i))
    begin
      wr_hit = 1'b1;
      wval   = mm_wdata_i[15:0];
    end
    else if (ser_wr && ctrl_index_hit(ser_index))
    begin
      wr_hit = 1'b1;
      wval   = ser_wdata;
    end

    if (wr_hit)
    begin
      if (wval[EPHY_BIT_SOFT_RST])
      begin
        next_r.ctrl     = CTRL_DEFAULT;
        next_r.soft_rst = 1'b1;
        start_neg       = 1'b1;
      end
      else
      begin
        next_r.ctrl = ctrl_unpack(wval & EPHY_CTRL_WMASK);
        start_neg   = wval[EPHY_BIT_RESTART];
      end
    end

    // Loader image replaces the whole register, taking priority over writes
    if (load_i)
    begin
      next_r.ctrl = ctrl_unpack(load_data_i & EPHY_CTRL_WMASK);
      start_neg   = load_data_i[EPHY_BIT_RESTART];
      if (load_data_i[EPHY_BIT_SOFT_RST])
      begin
        next_r.ctrl     = CTRL_DEFAULT;
        next_r.soft_rst = 1'b1;
        start_neg       = 1'b1;
      end
    end

    // Emulated negotiation: a fixed delay then the partner abilities latch
    // Writes during a run leave it going; only a new restart or a soft reset rearms it
    if (start_neg)
    begin
      next_r.neg_busy = 1'b1;
      next_r.neg_cnt  = 8'h00;
      next_r.neg_done = 1'b0;
    end
    else if (r.neg_busy)
    begin
      next_r.neg_cnt = r.neg_cnt + 8'h01;
      if (r.neg_cnt == 8'(EPHY_NEG_CYCLES - 1))
      begin
        next_r.neg_busy     = 1'b0;
        next_r.neg_done     = 1'b1;
        next_r.neg_fast     = partner_fast_i;
        next_r.neg_full     = partner_full_i;
        next_r.ctrl.restart = 1'b0;
      end
    end

    // Memory-mapped read, upper half and unmapped addresses read zero
    if (mm_rd_i)
      next_r.rdata = ctrl_addr_hit(mm_addr_i) ? {16'h0000, ctrl_view}
                                                      : 32'h0000_0000;

    // MAC transmit path, two flops because the pins are outside this clock
    next_r.tx_en_sync = {r.tx_en_sync[0], mac_tx_en_i};
    next_r.txd_s1     = mac_txd_i;
    next_r.txd_s2     = r.txd_s1;

    // Looped frames never reach the fabric, so the switch sees an idle port
    if (r.ctrl.loop)
    begin
      next_r.fab_valid = 1'b0;
      next_r.fab_d     = '0;
      next_r.rx_dv     = tx_en_eff;
      next_r.rxd       = tx_en_eff ? r.txd_s2 : '0;
    end
    else
    begin
      next_r.fab_valid = tx_en_eff;
      next_r.fab_d     = tx_en_eff ? r.txd_s2 : '0;
      next_r.rx_dv     = fabric_rx_valid_i;
      next_r.rxd       = fabric_rx_valid_i ? fabric_rxd_i : '0;
    end
    // Collision follows transmit even without loopback; pairing is only advised
    next_r.col = r.ctrl.col_test && tx_en_eff;
  end

  // Negotiation is armed in reset so results are fresh soon after release
  always_ff @(posedge core_clk_i or negedge resetn_i)
  begin
    if (!resetn_i)
    begin
      r          <= '0;
      r.ctrl     <= CTRL_DEFAULT;
      r.neg_busy <= 1'b1;
    end
    else
    begin
      r <= next_r;
    end
  end

  //////////////////////////////////////////////////////////////////////////////
  assign mm_rdata_o        = r.rdata;
  assign mac_rx_dv_o       = r.rx_dv;
  assign mac_rxd_o         = r.rxd;
  assign mac_col_o         = r.col;
  // The management pins are handled by u_mdio and never see isolation
  assign mac_out_oe_o      = !isolated;
  assign mii_pull_en_o     = !isolated;
  assign fabric_tx_valid_o = r.fab_valid;
  assign fabric_txd_o      = r.fab_d;
  // Effective link settings fall back to the forced bits without negotiation
  assign link_fast_o       = r.ctrl.neg_en ? r.neg_fast : r.ctrl.speed;
  assign link_full_o       = r.ctrl.neg_en ? r.neg_full : r.ctrl.duplex;
  assign neg_done_o        = r.neg_done;
  assign soft_reset_o      = r.soft_rst;

endmodule // ephy_basic_control

//--- hw/ephy_pkg.sv
// Constants and types shared by the emulated PHY basic control block
package ephy_pkg;

  //////////////////////////////////////////////////////////////////////////////
  localparam logic [11:0] EPHY_CTRL_OFFSET = 12'h1c0;
  localparam logic [4:0]  EPHY_CTRL_INDEX  = 5'h00;
  localparam logic [15:0] EPHY_CTRL_RESET  = 16'h1000;
  localparam logic [15:0] EPHY_CTRL_WMASK  = 16'h7f80;

  localparam int EPHY_BIT_SOFT_RST = 15;
  localparam int EPHY_BIT_LOOP     = 14;
  localparam int EPHY_BIT_SPEED    = 13;
  localparam int EPHY_BIT_NEG_EN   = 12;
  localparam int EPHY_BIT_PWR_DN   = 11;
  localparam int EPHY_BIT_ISO      = 10;
  localparam int EPHY_BIT_RESTART  = 9;
  localparam int EPHY_BIT_DUPLEX   = 8;
  localparam int EPHY_BIT_COL_TEST = 7;

  //////////////////////////////////////////////////////////////////////////////
  localparam int EPHY_PREAMBLE_LEN = 32;
  localparam int EPHY_HDR_BITS     = 13;
  localparam int EPHY_DATA_BITS    = 16;
  localparam logic [1:0] EPHY_OP_READ  = 2'h2;
  localparam logic [1:0] EPHY_OP_WRITE = 2'h1;

  //////////////////////////////////////////////////////////////////////////////
  localparam int EPHY_CLK_PERIOD_NS = 50;
  localparam int EPHY_NEG_TIME_NS   = 1000;
  localparam int EPHY_NEG_CYCLES    =
    (EPHY_NEG_TIME_NS + EPHY_CLK_PERIOD_NS - 1) / EPHY_CLK_PERIOD_NS;

  typedef enum logic [1:0] {
    EPHY_MODE_MAC     = 2'b00,
    EPHY_MODE_PHY_MII = 2'b01,
    EPHY_MODE_PHY_RMII = 2'b10,
    EPHY_MODE_RSVD    = 2'b11
  } ephy_mode_e;

  typedef enum logic [1:0] {
    EPHY_MS_PRE  = 2'b00,
    EPHY_MS_HDR  = 2'b01,
    EPHY_MS_TA   = 2'b10,
    EPHY_MS_DATA = 2'b11
  } ephy_mdio_state_e;

  function automatic logic ephy_is_phy_mode(input logic [1:0] mode);
    ephy_is_phy_mode = (mode == EPHY_MODE_PHY_MII) || (mode == EPHY_MODE_PHY_RMII);
  endfunction

endpackage

//--- hw/ephy_mdio_slave.sv
// Serial management frame slave for the emulated PHY
`timescale 1ns/10ps
module ephy_mdio_slave
  import ephy_pkg::*;
(
  input  wire logic        core_clk_i,   // System clock
  input  wire logic        resetn_i,     // Async reset, active low
  input  wire logic        mdc_i,        // Management clock pin
  input  wire logic        mdio_i,       // Management data pin, input side
  output logic             mdio_o,       // Management data, output side
  output logic             mdio_oe_o,    // Management data drive enable
  input  wire logic        enable_i,     // Serial access allowed
  input  wire logic [4:0]  phy_addr_i,   // Address this slave answers
  input  wire logic [15:0] rd_data_i,    // Read data for reg_index_o
  output logic [4:0]       reg_index_o,  // Register index of current frame
  output logic             wr_o,         // One-cycle write pulse
  output logic [15:0]      wr_data_o     // Write data
);

  typedef struct packed {
    logic [1:0]       mdc_sync;
    logic [1:0]       mdio_sync;
    logic             mdc_last;
    ephy_mdio_state_e state;
    logic [5:0]       cnt;
    logic [12:0]      hdr;
    logic [15:0]      shift;
    logic             is_read;
    logic             hit;
    logic             drive;
    logic             out;
    logic             wr;
    logic [15:0]      wr_data;
  } ephy_mdio_s;

  ephy_mdio_s r;
  ephy_mdio_s next_r;
  logic       rise;
  logic       bit_in;
  logic [12:0] hdr_new;

  //////////////////////////////////////////////////////////////////////////////
  always_comb
  begin
    next_r            = r;
    next_r.mdc_sync   = {r.mdc_sync[0], mdc_i};
    next_r.mdio_sync  = {r.mdio_sync[0], mdio_i};
    next_r.mdc_last   = r.mdc_sync[1];
    next_r.wr         = 1'b0;
    rise              = r.mdc_sync[1] && !r.mdc_last;
    bit_in            = r.mdio_sync[1];
    hdr_new           = {r.hdr[11:0], bit_in};
    if (rise)
    begin
      case (r.state)
        EPHY_MS_PRE:
        begin
          // Suppressed preamble is not accepted: a full run of ones is needed
          if (bit_in)
            next_r.cnt = (r.cnt == 6'(EPHY_PREAMBLE_LEN)) ? r.cnt : r.cnt + 6'h01;
          else if (r.cnt == 6'(EPHY_PREAMBLE_LEN))
          begin
            next_r.state = EPHY_MS_HDR;
            next_r.cnt   = 6'h00;
          end
          else
            next_r.cnt = 6'h00;
        end
        EPHY_MS_HDR:
        begin
          next_r.hdr = hdr_new;
          next_r.cnt = r.cnt + 6'h01;
          if (r.cnt == 6'(EPHY_HDR_BITS - 1))
          begin
            next_r.cnt     = 6'h00;
            next_r.is_read = (hdr_new[11:10] == EPHY_OP_READ);
            next_r.hit     = enable_i && (hdr_new[9:5] == phy_addr_i);
            if (hdr_new[12] && ((hdr_new[11:10] == EPHY_OP_READ) ||
                                (hdr_new[11:10] == EPHY_OP_WRITE)))
              next_r.state = EPHY_MS_TA;
            else
              next_r.state = EPHY_MS_PRE;
          end
        end
        EPHY_MS_TA:
        begin
          next_r.cnt = r.cnt + 6'h01;
          if (r.cnt == 6'h00)
          begin
            next_r.drive = r.is_read && r.hit;
            next_r.out   = 1'b0;
          end
          else
          begin
            next_r.state = EPHY_MS_DATA;
            next_r.cnt   = 6'h00;
            next_r.out   = rd_data_i[15];
            next_r.shift = {rd_data_i[14:0], 1'b0};
          end
        end
        EPHY_MS_DATA:
        begin
          next_r.cnt = r.cnt + 6'h01;
          if (r.is_read)
          begin
            next_r.out   = r.shift[15];
            next_r.shift = {r.shift[14:0], 1'b0};
          end
          else
            next_r.shift = {r.shift[14:0], bit_in};
          if (r.cnt == 6'(EPHY_DATA_BITS - 1))
          begin
            next_r.state = EPHY_MS_PRE;
            next_r.cnt   = 6'h00;
            next_r.drive = 1'b0;
            next_r.out   = 1'b0;
            if (!r.is_read && r.hit)
            begin
              next_r.wr      = 1'b1;
              next_r.wr_data = {r.shift[14:0], bit_in};
            end
          end
        end
        default:
        begin
          next_r.state = EPHY_MS_PRE;
          next_r.cnt   = 6'h00;
        end
      endcase
    end
  end

  always_ff @(posedge core_clk_i or negedge resetn_i)
  begin
    if (!resetn_i)
      r <= '0;
    else
      r <= next_r;
  end

  //////////////////////////////////////////////////////////////////////////////
  assign mdio_o      = r.out;
  assign mdio_oe_o   = r.drive;
  assign reg_index_o = r.hdr[4:0];
  assign wr_o        = r.wr;
  assign wr_data_o   = r.wr_data;

endmodule // ephy_mdio_slave

//--- testbench/ephy_basic_control_properties.sv
// Port assertions for the emulated PHY basic control register
`timescale 1ns/10ps
module ephy_basic_control_properties
  import ephy_pkg::*;
(
  input wire logic        core_clk_i,        // Clock
  input wire logic        resetn_i,          // Reset
  input wire logic [11:0] mm_addr_i,         // Address
  input wire logic        mm_rd_i,           // Read
  input wire logic [31:0] mm_rdata_o,        // Data
  input wire logic [1:0]  port_mode_i,       // Mode
  input wire logic        mdio_oe_o,         // Drive
  input wire logic        mac_tx_en_i,       // Tx
  input wire logic        mac_col_o,         // Col
  input wire logic        mac_out_oe_o,      // MII drive
  input wire logic        mii_pull_en_o,     // Pulls
  input wire logic        fabric_tx_valid_o, // Fabric
  input wire logic        neg_done_o,        // Done
  input wire logic        soft_reset_o       // Pulse
);
  // Saturating count of negotiating cycles, so a stuck run cannot wrap past the check
  logic [4:0] low_cnt;
  always_ff @(posedge core_clk_i or negedge resetn_i)
  begin
    if (!resetn_i)
      low_cnt <= 5'h00;
    else if (neg_done_o)
      low_cnt <= 5'h00;
    else if (low_cnt != 5'h1f)
      low_cnt <= low_cnt + 5'h01;
  end
  default clocking cb @(posedge core_clk_i); endclocking
  default disable iff (!resetn_i);
  property p_mac_pins; !ephy_is_phy_mode(port_mode_i) |-> mac_out_oe_o; endproperty
  property p_pulls; mii_pull_en_o == mac_out_oe_o; endproperty
  property p_col; mac_col_o |-> $past(mac_tx_en_i, 3); endproperty
  property p_fabric; fabric_tx_valid_o |-> $past(mac_tx_en_i, 3); endproperty
  property p_soft; soft_reset_o |-> ##[0:1] !neg_done_o; endproperty
  property p_neg; $rose(neg_done_o) |-> low_cnt inside {[5'h13:5'h15]}; endproperty
  property p_quiet;
    !ephy_is_phy_mode(port_mode_i) && !ephy_is_phy_mode($past(port_mode_i, 2)) |-> !mdio_oe_o;
  endproperty
  property p_zero; (mm_rdata_o & 32'hffff807f) == 32'h0; endproperty
  property p_other;
    $past(mm_rd_i) && ($past(mm_addr_i) != EPHY_CTRL_OFFSET) |-> mm_rdata_o == 32'h0;
  endproperty
  a_mac_pins: assert property (p_mac_pins)
    else $error("MII pins released in MAC mode");
  a_pulls: assert property (p_pulls)
    else $error("pulls differ from drive");
  a_col: assert property (p_col)
    else $error("collision without transmit");
  a_fabric: assert property (p_fabric)
    else $error("fabric data without transmit");
  a_soft: assert property (p_soft)
    else $error("soft reset kept negotiation done");
  a_neg: assert property (p_neg)
    else $error("negotiation length wrong");
  a_quiet: assert property (p_quiet)
    else $error("serial drive in MAC mode");
  a_zero: assert property (p_zero)
    else $error("fixed bits read nonzero");
  a_other: assert property (p_other)
    else $error("unmapped read nonzero");
  c_soft: cover property (soft_reset_o);
  c_col: cover property (mac_col_o);
  c_ser: cover property (mdio_oe_o);
endmodule // ephy_basic_control_properties

//--- testbench/ephy_mgmt_master.sv
// Management controller model of the external MAC
`timescale 1ns/10ps
module ephy_mgmt_master
  import ephy_pkg::*;
(
  input  wire logic core_clk_i, // Clock
  input  wire logic mdio_i,     // Line
  output logic      mdc_o,      // MDC
  output logic      mdio_o,     // Data
  output logic      mdio_oe_o   // Drive
);
  logic [63:0] fr;
  initial
  begin
    mdc_o = 1'b0;
    mdio_o = 1'b1;
    mdio_oe_o = 1'b0;
  end
  // Eight system clocks a bit give exactly 2.5 MHz; MDC stands low between frames
  task automatic frame(input logic [1:0] op, input logic [4:0] pa, input logic [4:0] ra,
                       input logic [15:0] wd, output logic [15:0] rdv);
    fr = {32'hffffffff, 2'b01, op, pa, ra, 2'b10, wd};
    for (int i = 63; i >= 0; i--)
    begin
      repeat (4) @(negedge core_clk_i);
      mdc_o = 1'b0;
      mdio_oe_o = !(op == EPHY_OP_READ && i <= 17);
      mdio_o = fr[i];
      repeat (4) @(negedge core_clk_i);
      mdc_o = 1'b1;
      rdv = {rdv[14:0], mdio_i};
    end
    repeat (4) @(negedge core_clk_i);
    mdc_o = 1'b0;
    mdio_oe_o = 1'b0;
  endtask
endmodule // ephy_mgmt_master

//--- testbench/ephy_basic_control_tb_top.sv
// Self-checking bench for the emulated PHY basic control register
`timescale 1ns/10ps
module ephy_basic_control_tb_top
  import ephy_pkg::*;
;
  logic        clk, rstn, wr, rd, ld, txen, pf, pu, moe, mdo, m_oe, m_mdo, mdc, mdi;
  logic        dv, col, oe, pull, fv, lf, lu, nd, sr, iso, lp;
  logic [1:0]  mode;
  logic [3:0]  txd, rxd, ftxd;
  logic [4:0]  strap;
  logic [11:0] addr;
  logic [15:0] ldat, sd;
  logic [31:0] wdat, rdat, d, v, e;
  logic [31:0] seed = 32'h75e2c35f;
  int          fail_count, total_checks, mreg, pfl, pul;
  int          exp_q[$];
  assign mdi = moe ? mdo : (m_oe ? m_mdo : 1'b1); // Pulled up when released
  ephy_basic_control #(.DATA_W(4)) DUT (
    .core_clk_i(clk), .resetn_i(rstn), .mm_addr_i(addr), .mm_wr_i(wr), .mm_rd_i(rd),
    .mm_wdata_i(wdat), .mm_rdata_o(rdat), .load_i(ld), .load_data_i(ldat),
    .phy_addr_strap_i(strap), .port_mode_i(mode), .mdc_i(mdc), .mdio_i(mdi),
    .mdio_o(mdo), .mdio_oe_o(moe), .partner_fast_i(pf), .partner_full_i(pu),
    .mac_tx_en_i(txen), .mac_txd_i(txd), .mac_rx_dv_o(dv), .mac_rxd_o(rxd),
    .mac_col_o(col), .mac_out_oe_o(oe), .mii_pull_en_o(pull), .fabric_tx_valid_o(fv),
    .fabric_txd_o(ftxd), .fabric_rx_valid_i(1'b0), .fabric_rxd_i(4'h0),
    .link_fast_o(lf), .link_full_o(lu), .neg_done_o(nd), .soft_reset_o(sr));
  ephy_mgmt_master u_mac (.core_clk_i(clk), .mdio_i(mdi), .mdc_o(mdc), .mdio_o(m_mdo),
    .mdio_oe_o(m_oe));
  //////////////////////////////////////////////////////////////////////////////
  function automatic logic [31:0] rnd();
    seed = seed ^ (seed << 13);
    seed = seed ^ (seed >> 17);
    seed = seed ^ (seed << 5);
    return seed;
  endfunction
  task automatic close_out();
    if (fail_count == 0 && total_checks > 0)
      $display("RESULT: PASS");
    else
      $display("RESULT: FAIL");
    $finish;
  endtask
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    total_checks++;
    if (got !== exp)
    begin
      fail_count++;
      $display("BAD t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  task automatic mmw(input logic [11:0] a, input logic [31:0] dat);
    @(negedge clk);
    addr = a;
    wdat = dat;
    wr = 1'b1;
    @(negedge clk);
    wr = 1'b0;
  endtask
  task automatic mmr(input logic [11:0] a, input logic [31:0] exp);
    @(negedge clk);
    addr = a;
    rd = 1'b1;
    @(negedge clk);
    rd = 1'b0;
    chk(rdat, exp);
  endtask
  // Negotiation latches the partner abilities when it completes
  task automatic wait_neg();
    for (int n = 0; n < 40 && nd !== 1'b1; n++)
      @(negedge clk);
    if (nd !== 1'b1)
    begin
      fail_count++;
      close_out();
    end
    else
    begin
      pfl = pf;
      pul = pu;
    end
  endtask
  task automatic chk_link();
    chk({lf, lu}, mreg[12] ? {pfl[0], pul[0]} : {mreg[13], mreg[8]});
  endtask
  //////////////////////////////////////////////////////////////////////////////
  initial
  begin
    clk = 1'b0;
    forever #25 clk = ~clk;
  end
  initial
  begin
    repeat (20000) @(posedge clk);
    fail_count++;
    close_out();
  end
  initial
  begin
    {rstn, wr, rd, ld, txen, pu, addr, wdat, ldat, txd} = '0;
    pf = 1'b1;
    mode = 2'h1;
    strap = 5'h0b;
    repeat (4) @(negedge clk);
    rstn = 1'b1;
    mreg = 32'h1000;
    wait_neg();
    mmr(12'h1c0, mreg);
    chk_link();
    for (int i = 0; i < 8; i++)
    begin
      d = rnd() & 32'hffff7dff;
      mmw(12'h1c0, d);
      mreg = d & 32'h7f80;
      mmr(12'h1c0, mreg);
      chk_link();
      mmw(12'h1c4, ~d);
      mmr(12'h1c4, 32'h0);
      mmr(12'h1c0, mreg);
    end
    mmw(12'h1c0, 32'h1000);
    pf = ~pf;
    pu = ~pu;
    mmw(12'h1c0, 32'h1200);
    mmr(12'h1c0, 32'h1200);
    wait_neg();
    mreg = 32'h1000;
    mmr(12'h1c0, mreg);
    chk_link();
    mmw(12'h1c0, 32'h0000e980);
    mmr(12'h1c0, mreg);
    wait_neg();
    d = rnd() & 32'h7dff;
    @(negedge clk);
    ldat = d[15:0];
    ld = 1'b1;
    @(negedge clk);
    ld = 1'b0;
    mmr(12'h1c0, d & 32'h7f80);
    // Collision test rides on loopback, as the managing side is advised
    for (int m = 0; m < 6; m++)
    begin
      d = (m < 4) ? 32'h5480 : ((m == 4) ? 32'h5080 : 32'h1000);
      mode = (m < 4) ? m[1:0] : 2'h1;
      mmw(12'h1c0, d);
      v = rnd();
      txd = v[3:0];
      txen = 1'b1;
      repeat (4) @(negedge clk);
      iso = d[10] && (mode == 2'h1 || mode == 2'h2);
      lp = d[14] && !iso;
      e = {!iso, !iso, !iso && !lp, d[7] && !iso, lp, lp ? txd : 4'h0,
           (!iso && !lp) ? txd : 4'h0};
      chk({oe, pull, fv, col, dv, rxd, ftxd}, e);
      txen = 1'b0;
      repeat (4) @(negedge clk);
    end
    mmw(12'h1c0, 32'h1400);
    d = (rnd() & 32'h7dff) | 32'h0400;
    u_mac.frame(EPHY_OP_WRITE, strap, 5'h00, d[15:0], sd);
    mreg = d & 32'h7f80;
    mmr(12'h1c0, mreg);
    exp_q.push_back(mreg);
    u_mac.frame(EPHY_OP_READ, strap, 5'h00, 16'h0, sd);
    chk(sd, exp_q.pop_front());
    u_mac.frame(EPHY_OP_READ, strap ^ 5'h01, 5'h00, 16'h0, sd);
    chk(sd, 32'hffff);
    mode = 2'h0;
    u_mac.frame(EPHY_OP_WRITE, strap, 5'h00, 16'h0000, sd);
    mmr(12'h1c0, mreg);
    u_mac.frame(EPHY_OP_READ, strap, 5'h00, 16'h0, sd);
    chk(sd, 32'hffff);
    close_out();
  end
endmodule // ephy_basic_control_tb_top
bind ephy_basic_control ephy_basic_control_properties u_props (
  .core_clk_i(core_clk_i), .resetn_i(resetn_i), .mm_addr_i(mm_addr_i), .mm_rd_i(mm_rd_i),
  .mm_rdata_o(mm_rdata_o), .port_mode_i(port_mode_i), .mdio_oe_o(mdio_oe_o),
  .mac_tx_en_i(mac_tx_en_i), .mac_col_o(mac_col_o), .mac_out_oe_o(mac_out_oe_o),
  .mii_pull_en_o(mii_pull_en_o), .fabric_tx_valid_o(fabric_tx_valid_o),
  .neg_done_o(neg_done_o), .soft_reset_o(soft_reset_o));
